//--- scs_activity_mon.sv
// edge activity monitor: flags a waveform as running while edges keep coming
`timescale 1ns/10ps
module scs_activity_mon
    import scs_pkg::*;
#(
    parameter logic [SCS_MON_W-1:0] TIMEOUT = 12'hFFF
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // sampled waveform
    input  wire logic sig_i,
    // status
    output logic      active_o
);

    logic                 prev;
    logic [SCS_MON_W-1:0] idle_cnt;
    logic                 edge_seen;
    logic                 saturated;
    logic [SCS_MON_W-1:0] next_idle_cnt;

    assign edge_seen     = sig_i & ~prev;
    assign saturated     = (idle_cnt >= TIMEOUT);
    assign next_idle_cnt = edge_seen ? '0 :
                           saturated ? idle_cnt :
                           idle_cnt + 1'b1;

    // starts out idle so a source that stays low is never taken as running
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prev     <= 1'b0;
            idle_cnt <= TIMEOUT;
            active_o <= 1'b0;
        end else begin
            prev     <= sig_i;
            idle_cnt <= next_idle_cnt;
            active_o <= (next_idle_cnt < TIMEOUT);
        end
    end

endmodule : scs_activity_mon

//--- scs_clock_control.sv
// system clock source control: registers, source selection and monitors
//
// Function
// - Any reset puts the system clock back on the internal oscillator.
// - While the reset pin is low both oscillators are held disabled.
// - Bit 3 of internal_osc_control picks internal (0) or external (1).
// - Missing clock enable bit 7 arms a detector that raises a reset.
// - Bits 6 and 5 of internal_osc_control read zero and ignore writes.
// - The frequency-ready flag reads one only while at the chosen speed.
// - Enable bit 2 switches the internal oscillator on or off.
// - The two-bit frequency field picks 2, 4, 8 or 16 MHz.
// - The internal oscillator is usable as soon as it is enabled.
// - The crystal-valid flag rises once a 1xx-mode crystal runs stably.
// - The mode field picks off, CMOS, RC/C or crystal, some halved.
// - Bit 3 of external_osc_control is reserved and ignores writes.
// - The external oscillator may run while internal clocks the chip.
`timescale 1ns/10ps
module scs_clock_control
    import scs_pkg::*;
#(
    parameter int XTAL_SETTLE_CYC = SCS_XTAL_SETTLE_CYC
) (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // reset pin, active low, asynchronous
    input  wire logic       rst_pin_n_i,
    // special function register port
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    // internal oscillator (analog macro)
    input  wire logic       int_osc_wave_i,
    input  wire logic       int_osc_locked_i,
    output logic            int_osc_enable_o,
    output logic      [1:0] int_freq_select_o,
    // external oscillator drive circuit
    input  wire logic       ext_clock_pin_a_i,
    output logic      [2:0] ext_osc_mode_o,
    output logic      [2:0] ext_drive_select_o,
    output logic            ext_clock_pin_a_ground_o,
    // system clock and missing clock reset
    output logic            sysclk_o,
    output logic            sysclk_is_ext_o,
    output logic            missing_clock_reset_o
);

    // two-flop synchronisers for every pin-side input
    localparam int SYNC_W = 4;
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_s1;
    logic [SYNC_W-1:0] sync_s2;

    assign sync_in = {rst_pin_n_i, int_osc_wave_i,
                      int_osc_locked_i, ext_clock_pin_a_i};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    sync_s1[gi] <= 1'b0;
                    sync_s2[gi] <= 1'b0;
                end else begin
                    sync_s1[gi] <= sync_in[gi];
                    sync_s2[gi] <= sync_s1[gi];
                end
            end
        end
    endgenerate

    logic pin_rst;
    logic int_wave_s;
    logic int_locked_s;
    logic ext_pin_s;

    assign pin_rst      = ~sync_s2[3];
    assign int_wave_s   = sync_s2[2];
    assign int_locked_s = sync_s2[1];
    assign ext_pin_s    = sync_s2[0];

    // every reset source returns the block to its boot state
    logic any_rst;
    assign any_rst = rst_i | pin_rst | missing_clock_reset_o;

    // register file
    scs_int_ctrl_t int_ctrl;
    scs_ext_ctrl_t ext_ctrl;
    scs_sfr_req_t  req;
    logic          wr_int;
    logic          wr_ext;
    logic          crystal_valid;
    logic          int_freq_ready;

    assign req    = '{addr: sfr_addr_i, wr: sfr_wr_i, wdata: sfr_wdata_i};
    assign wr_int = req.wr && (req.addr == SCS_INT_OSC_CONTROL_ADDR);
    assign wr_ext = req.wr && (req.addr == SCS_EXT_OSC_CONTROL_ADDR);

    localparam scs_int_ctrl_t INT_RST = '{
        missing_clock_enable:
            SCS_INT_OSC_CONTROL_RST[SCS_MISSING_CLOCK_ENABLE_BIT],
        sysclk_source_select:
            SCS_INT_OSC_CONTROL_RST[SCS_SYSCLK_SOURCE_SELECT_BIT],
        int_osc_enable:       SCS_INT_OSC_CONTROL_RST[SCS_INT_OSC_ENABLE_BIT],
        int_freq_select:
            SCS_INT_OSC_CONTROL_RST[SCS_INT_FREQ_SELECT_LSB +: 2]
    };
    localparam scs_ext_ctrl_t EXT_RST = '{
        ext_osc_mode:     SCS_EXT_OSC_CONTROL_RST[SCS_EXT_OSC_MODE_LSB +: 3],
        ext_drive_select: SCS_EXT_OSC_CONTROL_RST[SCS_EXT_DRIVE_SELECT_LSB +: 3]
    };

    scs_int_ctrl_t next_int_ctrl;
    scs_ext_ctrl_t next_ext_ctrl;

    // bits 6..5 and the read-only flag are simply not stored
    assign next_int_ctrl = wr_int ? '{
        missing_clock_enable: req.wdata[SCS_MISSING_CLOCK_ENABLE_BIT],
        sysclk_source_select: req.wdata[SCS_SYSCLK_SOURCE_SELECT_BIT],
        int_osc_enable:       req.wdata[SCS_INT_OSC_ENABLE_BIT],
        int_freq_select:      req.wdata[SCS_INT_FREQ_SELECT_LSB +: 2]
    } : int_ctrl;

    // bit 3 and the crystal-valid flag are not stored
    assign next_ext_ctrl = wr_ext ? '{
        ext_osc_mode:     req.wdata[SCS_EXT_OSC_MODE_LSB +: 3],
        ext_drive_select: req.wdata[SCS_EXT_DRIVE_SELECT_LSB +: 3]
    } : ext_ctrl;

    always_ff @(posedge ref_clk_i) begin
        if (any_rst) begin
            int_ctrl <= INT_RST;
            ext_ctrl <= EXT_RST;
        end else begin
            int_ctrl <= next_int_ctrl;
            ext_ctrl <= next_ext_ctrl;
        end
    end

    // read mux, one cycle after the address
    logic [7:0] rd_int;
    logic [7:0] rd_ext;
    logic [7:0] next_rdata;

    assign rd_int = {int_ctrl.missing_clock_enable,
                     2'h0,
                     int_freq_ready,
                     int_ctrl.sysclk_source_select,
                     int_ctrl.int_osc_enable,
                     int_ctrl.int_freq_select};
    assign rd_ext = {crystal_valid,
                     ext_ctrl.ext_osc_mode,
                     1'b0,
                     ext_ctrl.ext_drive_select};
    assign next_rdata = (req.addr == SCS_INT_OSC_CONTROL_ADDR) ? rd_int :
                        (req.addr == SCS_EXT_OSC_CONTROL_ADDR) ? rd_ext :
                        8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else begin
            sfr_rdata_o <= next_rdata;
        end
    end

    // oscillator controls toward the analog side
    logic       int_en_eff;
    logic [2:0] ext_mode_eff;
    logic       ext_off;

    assign int_en_eff   = int_ctrl.int_osc_enable & ~pin_rst;
    assign ext_mode_eff = pin_rst ? SCS_XMODE_OFF0
                                  : ext_ctrl.ext_osc_mode;
    assign ext_off      = (ext_mode_eff == SCS_XMODE_OFF0) ||
                          (ext_mode_eff == SCS_XMODE_OFF1);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            int_osc_enable_o         <= 1'b0;
            int_freq_select_o        <= SCS_IFREQ_2MHZ;
            ext_osc_mode_o           <= SCS_XMODE_OFF0;
            ext_drive_select_o       <= 3'h0;
            ext_clock_pin_a_ground_o <= 1'b1;
        end else begin
            int_osc_enable_o         <= int_en_eff;
            int_freq_select_o        <= int_ctrl.int_freq_select;
            ext_osc_mode_o           <= ext_mode_eff;
            ext_drive_select_o       <= ext_ctrl.ext_drive_select;
            ext_clock_pin_a_ground_o <= ext_off;
        end
    end

    // ready only while enabled and the oscillator reports lock
    assign int_freq_ready = int_en_eff & int_locked_s;

    // external waveform: optional divide by two per mode
    logic ext_div2_mode;
    logic ext_prev;
    logic ext_half;
    logic ext_wave;
    logic int_wave;

    assign ext_div2_mode = (ext_mode_eff == SCS_XMODE_CMOS_DIV2) ||
                           (ext_mode_eff == SCS_XMODE_RC0_DIV2) ||
                           (ext_mode_eff == SCS_XMODE_RC1_DIV2) ||
                           (ext_mode_eff == SCS_XMODE_XTAL_DIV2);

    always_ff @(posedge ref_clk_i) begin
        if (any_rst) begin
            ext_prev <= 1'b0;
            ext_half <= 1'b0;
        end else begin
            ext_prev <= ext_pin_s;
            if (ext_pin_s && !ext_prev) begin
                ext_half <= ~ext_half;
            end
        end
    end

    assign ext_wave = ext_off ? 1'b0 :
                      ext_div2_mode ? ext_half : ext_pin_s;
    // no settling gate on the internal source
    assign int_wave = int_en_eff & int_wave_s;

    // crystal qualification: running, then stable for the settle time
    logic                    ext_active;
    logic                    xtal_mode;
    logic [SCS_SETTLE_W-1:0] settle_cnt;
    logic                    settle_done;

    assign xtal_mode   = ext_mode_eff[2];
    assign settle_done = (settle_cnt >= XTAL_SETTLE_CYC[SCS_SETTLE_W-1:0]);

    scs_activity_mon #(
        .TIMEOUT (SCS_MISSING_CYC[SCS_MON_W-1:0])
    ) u_ext_mon (
        .ref_clk_i (ref_clk_i),
        .rst_i     (any_rst),
        .sig_i     (ext_pin_s),
        .active_o  (ext_active)
    );

    always_ff @(posedge ref_clk_i) begin
        if (any_rst || !xtal_mode || !ext_active) begin
            settle_cnt <= '0;
        end else if (!settle_done) begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end

    assign crystal_valid = xtal_mode & ext_active & settle_done;

    // glitch-free source switch
    scs_glitchfree_mux u_mux (
        .ref_clk_i (ref_clk_i),
        .rst_i     (any_rst),
        .sel_i     (int_ctrl.sysclk_source_select),
        .src0_i    (int_wave),
        .src1_i    (ext_wave),
        .clk_o     (sysclk_o),
        .cur_sel_o (sysclk_is_ext_o)
    );

    // missing clock detector on the system clock
    logic sys_active;

    scs_activity_mon #(
        .TIMEOUT (SCS_MISSING_CYC[SCS_MON_W-1:0])
    ) u_sys_mon (
        .ref_clk_i (ref_clk_i),
        .rst_i     (any_rst),
        .sig_i     (sysclk_o),
        .active_o  (sys_active)
    );

    // armed only after the monitor has once seen the clock running
    logic seen_running;

    always_ff @(posedge ref_clk_i) begin
        if (any_rst || !int_ctrl.missing_clock_enable) begin
            seen_running <= 1'b0;
        end else if (sys_active) begin
            seen_running <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            missing_clock_reset_o <= 1'b0;
        end else begin
            missing_clock_reset_o <= int_ctrl.missing_clock_enable &
                                     seen_running & ~sys_active &
                                     ~missing_clock_reset_o;
        end
    end

endmodule : scs_clock_control

//--- scs_clock_control_properties.sv
// port assertions for the system clock source control block
`timescale 1ns/10ps
module scs_clock_control_properties
    import scs_pkg::*;
#(
    parameter int XTAL_SETTLE_CYC = SCS_XTAL_SETTLE_CYC
) (
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       rst_pin_n_i,
    // register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    // oscillators
    input wire logic       int_osc_wave_i,
    input wire logic       int_osc_locked_i,
    input wire logic       int_osc_enable_o,
    input wire logic [1:0] int_freq_select_o,
    input wire logic       ext_clock_pin_a_i,
    input wire logic [2:0] ext_osc_mode_o,
    input wire logic [2:0] ext_drive_select_o,
    input wire logic       ext_clock_pin_a_ground_o,
    // system clock
    input wire logic       sysclk_o,
    input wire logic       sysclk_is_ext_o,
    input wire logic       missing_clock_reset_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    // pin reset released long enough to reach the registers
    sequence pin_up;
        (rst_pin_n_i && !rst_i)[*4];
    endsequence

    a_pin_osc_off: assert property (!rst_pin_n_i[*4] |->
        !int_osc_enable_o && ext_osc_mode_o == 3'h0)
        else $error("oscillators on under pin reset");
    a_reset_int_src: assert property (@(posedge ref_clk_i)
        disable iff (1'b0) rst_i |=> !sysclk_is_ext_o)
        else $error("external source after reset");
    a_write_reaches: assert property (pin_up ##0 (sfr_wr_i &&
        sfr_addr_i == SCS_INT_OSC_CONTROL_ADDR && !missing_clock_reset_o)
        |=> ##1 int_freq_select_o == $past(sfr_wdata_i[1:0], 2) &&
        int_osc_enable_o == $past(sfr_wdata_i[2], 2))
        else $error("internal control write not applied");
    a_int_unused_zero: assert property (
        $past(sfr_addr_i) == SCS_INT_OSC_CONTROL_ADDR |->
        sfr_rdata_o[6:5] == 2'h0) else $error("unused bits not zero");
    a_ext_rsvd_zero: assert property (
        $past(sfr_addr_i) == SCS_EXT_OSC_CONTROL_ADDR |->
        !sfr_rdata_o[3]) else $error("reserved bit set");
    a_ready_needs_en: assert property (
        $past(sfr_addr_i) == SCS_INT_OSC_CONTROL_ADDR && sfr_rdata_o[4]
        |-> sfr_rdata_o[2]) else $error("ready with oscillator off");
    a_valid_needs_xtal: assert property (
        $past(sfr_addr_i) == SCS_EXT_OSC_CONTROL_ADDR && sfr_rdata_o[7]
        |-> sfr_rdata_o[6]) else $error("crystal valid outside 1xx");
    a_ground_tracks: assert property (pin_up |->
        ext_clock_pin_a_ground_o == (ext_osc_mode_o[2:1] == 2'h0))
        else $error("pin grounding does not match mode");
    a_mclk_one_cycle: assert property (missing_clock_reset_o |=>
        !missing_clock_reset_o) else $error("missing reset too long");
    a_mclk_to_int: assert property (missing_clock_reset_o |=> ##1
        !sysclk_is_ext_o) else $error("external kept after missing reset");
    a_mux_park: assert property (pin_up ##0 (
        $changed(sysclk_is_ext_o) &&
        !$past(missing_clock_reset_o) && !$past(missing_clock_reset_o, 2))
        |-> !$past(sysclk_o)) else $error("switch while clock high");

    c_int_write: cover property (sfr_wr_i &&
        sfr_addr_i == SCS_INT_OSC_CONTROL_ADDR);
    c_to_ext: cover property ($rose(sysclk_is_ext_o));
    c_missing: cover property (missing_clock_reset_o);
endmodule : scs_clock_control_properties

bind scs_clock_control scs_clock_control_properties #(
    .XTAL_SETTLE_CYC(XTAL_SETTLE_CYC)
) u_props (.ref_clk_i, .rst_i, .rst_pin_n_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .sfr_rdata_o, .int_osc_wave_i, .int_osc_locked_i,
    .int_osc_enable_o, .int_freq_select_o, .ext_clock_pin_a_i,
    .ext_osc_mode_o, .ext_drive_select_o, .ext_clock_pin_a_ground_o,
    .sysclk_o, .sysclk_is_ext_o, .missing_clock_reset_o);

//--- scs_clock_control_tb.sv
// self-checking bench for the system clock source control block
`timescale 1ns/10ps
module scs_clock_control_tb
    import scs_pkg::*;
;
    localparam int SETTLE = 20;
    localparam logic [7:0] INT = SCS_INT_OSC_CONTROL_ADDR;
    localparam logic [7:0] EXT = SCS_EXT_OSC_CONTROL_ADDR;

    logic       ref_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       rst_pin_n_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic       sfr_wr_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic       ext_run = 1'b1;
    logic [7:0] sfr_rdata_o;
    logic       int_wave, int_locked, ext_pin;
    logic       int_osc_enable_o, ground_o;
    logic [1:0] int_freq_select_o;
    logic [2:0] ext_osc_mode_o;
    logic       sysclk_is_ext_o, missing_clock_reset_o;
    logic [2:0] ext_drive_select_o;
    logic       sysclk_o;
    logic [7:0] d;
    int         i;
    int         bad_count = 0;
    int         cmp_count = 0;

    scs_clock_control #(.XTAL_SETTLE_CYC(SETTLE)) dut (
        .ref_clk_i, .rst_i, .rst_pin_n_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_wdata_i, .sfr_rdata_o, .int_osc_wave_i(int_wave),
        .int_osc_locked_i(int_locked), .int_osc_enable_o,
        .int_freq_select_o, .ext_clock_pin_a_i(ext_pin), .ext_osc_mode_o,
        .ext_drive_select_o, .ext_clock_pin_a_ground_o(ground_o),
        .sysclk_o, .sysclk_is_ext_o, .missing_clock_reset_o);

    scs_osc_model u_osc (.ref_clk_i, .int_en_i(int_osc_enable_o),
        .ext_run_i(ext_run), .ext_ground_i(ground_o),
        .int_wave_o(int_wave), .int_locked_o(int_locked),
        .ext_pin_o(ext_pin));

    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        tick(1);
        sfr_addr_i = a;
        sfr_wdata_i = v;
        sfr_wr_i = 1'b1;
        tick(1);
        sfr_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        sfr_addr_i = a;
        tick(1);
        d = sfr_rdata_o;
    endtask : rd

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wait_ext(input logic v);
        for (int k = 0; k < 200 && sysclk_is_ext_o !== v; k++) tick(1);
        chk_bit(sysclk_is_ext_o, v);
    endtask : wait_ext

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic t_reset_values;
        rd(INT);
        chk_reg(d, SCS_INT_OSC_CONTROL_RST | 8'h10);
        rd(EXT);
        chk_reg(d, SCS_EXT_OSC_CONTROL_RST);
        chk_bit(sysclk_is_ext_o, 1'b0);
    endtask : t_reset_values

    task automatic t_fields;
        for (i = 0; i < 4; i++) begin
            wr(INT, 8'h64 | 8'(i));
            rd(INT);
            chk_reg(d, 8'h14 | 8'(i));
            chk_reg({6'h00, int_freq_select_o}, 8'(i));
        end
        for (i = 0; i < 8; i++) begin
            wr(EXT, {1'b1, 3'(i), 4'hD});
            rd(EXT);
            chk_reg(d & 8'h7F, {1'b0, 3'(i), 4'h5});
            chk_reg({5'h00, ext_osc_mode_o}, 8'(i));
            chk_reg({5'h00, ext_drive_select_o}, 8'h05);
            chk_bit(ground_o, i < 2);
        end
    endtask : t_fields

    task automatic t_int_off;
        wr(INT, 8'h03);
        rd(INT);
        chk_reg(d, 8'h03);
        chk_bit(int_osc_enable_o, 1'b0);
        chk_bit(sysclk_o, 1'b0);
        wr(INT, 8'h04);
        tick(6);
        rd(INT);
        chk_reg(d, 8'h14);
    endtask : t_int_off

    task automatic t_xtal;
        wr(EXT, 8'h00);
        wr(EXT, 8'h67);
        rd(EXT);
        chk_bit(d[7], 1'b0);
        tick(SETTLE);
        for (i = 0; i < 300 && d[7] !== 1'b1; i++) rd(EXT);
        chk_bit(d[7], 1'b1);
        chk_bit(sysclk_is_ext_o, 1'b0);
        wr(INT, 8'h0C);
        wait_ext(1'b1);
        chk_bit(int_osc_enable_o, 1'b1);
        wr(INT, 8'h04);
        wait_ext(1'b0);
        wr(INT, 8'h0C);
        wait_ext(1'b1);
    endtask : t_xtal

    task automatic t_missing;
        wr(INT, 8'h8C);
        ext_run = 1'b0;
        for (i = 0; i < 3000 && missing_clock_reset_o !== 1'b1; i++) tick(1);
        chk_bit(missing_clock_reset_o, 1'b1);
        ext_run = 1'b1;
        wait_ext(1'b0);
        tick(6);
        rd(INT);
        chk_reg(d, 8'h14);
        rd(EXT);
        chk_reg(d, SCS_EXT_OSC_CONTROL_RST);
    endtask : t_missing

    task automatic t_pin;
        wr(INT, 8'h0C);
        wait_ext(1'b1);
        rst_pin_n_i = 1'b0;
        tick(5);
        chk_bit(int_osc_enable_o, 1'b0);
        chk_reg({5'h00, ext_osc_mode_o}, 8'h00);
        rst_pin_n_i = 1'b1;
        tick(8);
        rd(INT);
        chk_reg(d, 8'h14);
        chk_bit(sysclk_is_ext_o, 1'b0);
    endtask : t_pin

    initial begin
        tick(2);
        rst_i = 1'b0;
        tick(8);
        t_reset_values();
        t_fields();
        t_int_off();
        t_xtal();
        t_missing();
        t_pin();
        test_done();
    end

    initial begin
        #(40 * 20000);
        bad_count++;
        test_done();
    end
endmodule : scs_clock_control_tb

//--- scs_glitchfree_mux.sv
// glitch-free switch between two sampled oscillator waveforms
`timescale 1ns/10ps
module scs_glitchfree_mux
    import scs_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic sel_i,
    // sources
    input  wire logic src0_i,
    input  wire logic src1_i,
    // output
    output logic      clk_o,
    output logic      cur_sel_o
);

    typedef enum logic [1:0] {
        SCS_MUX_RUN  = 2'b01,
        SCS_MUX_PARK = 2'b10
    } scs_mux_state_t;

    scs_mux_state_t state;
    scs_mux_state_t next_state;
    logic           cur_src;
    logic           new_src;
    logic           next_clk;

    assign cur_src = cur_sel_o ? src1_i : src0_i;
    assign new_src = sel_i ? src1_i : src0_i;

    // leave the old source only on its low phase, join the new one only on
    // its low phase, so neither a cut high pulse nor a runt can appear
    always_comb begin
        next_state = state;
        next_clk   = 1'b0;
        case (state)
            SCS_MUX_RUN: begin
                next_clk = cur_src;
                if ((sel_i != cur_sel_o) && !cur_src) begin
                    next_state = SCS_MUX_PARK;
                    next_clk   = 1'b0;
                end
            end
            SCS_MUX_PARK: begin
                if (!new_src) begin
                    next_state = SCS_MUX_RUN;
                end
            end
            default: begin
                next_state = SCS_MUX_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state     <= SCS_MUX_RUN;
            clk_o     <= 1'b0;
            cur_sel_o <= 1'b0;
        end else begin
            state <= next_state;
            clk_o <= next_clk;
            if ((state == SCS_MUX_PARK) && !new_src) begin
                cur_sel_o <= sel_i;
            end
        end
    end

endmodule : scs_glitchfree_mux

//--- scs_osc_model.sv
// oscillator macro and external clock source model
`timescale 1ns/10ps
module scs_osc_model (
    // clock
    input  wire logic ref_clk_i,
    // controls
    input  wire logic int_en_i,
    input  wire logic ext_run_i,
    input  wire logic ext_ground_i,
    // waveforms
    output logic      int_wave_o = 1'b0,
    output logic      int_locked_o = 1'b0,
    output logic      ext_pin_o = 1'b0
);
    logic [1:0] int_cnt = 2'h0;
    logic [1:0] ext_cnt = 2'h0;

    always @(posedge ref_clk_i) begin
        int_cnt <= int_cnt + 2'h1;
        ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
        int_wave_o <= int_en_i & int_cnt[1];
        int_locked_o <= int_en_i;
        // external source runs whatever clocks the chip
        if (ext_ground_i || !ext_run_i) begin
            ext_pin_o <= 1'b0;
        end else if (ext_cnt == 2'h2) begin
            ext_pin_o <= ~ext_pin_o;
        end
    end
endmodule : scs_osc_model

//--- scs_pkg.sv
// system clock source control: register map, fields, reset values, timing
package scs_pkg;

    // register offsets
    localparam logic [7:0] SCS_EXT_OSC_CONTROL_ADDR = 8'hB1;
    localparam logic [7:0] SCS_INT_OSC_CONTROL_ADDR = 8'hB2;

    // reset values
    localparam logic [7:0] SCS_EXT_OSC_CONTROL_RST  = 8'h30;
    localparam logic [7:0] SCS_INT_OSC_CONTROL_RST  = 8'h04;

    // internal_osc_control field positions
    localparam int SCS_MISSING_CLOCK_ENABLE_BIT = 7;
    localparam int SCS_INT_FREQ_READY_BIT       = 4;
    localparam int SCS_SYSCLK_SOURCE_SELECT_BIT = 3;
    localparam int SCS_INT_OSC_ENABLE_BIT       = 2;
    localparam int SCS_INT_FREQ_SELECT_LSB      = 0;

    // external_osc_control field positions
    localparam int SCS_CRYSTAL_VALID_BIT        = 7;
    localparam int SCS_EXT_OSC_MODE_LSB         = 4;
    localparam int SCS_EXT_DRIVE_SELECT_LSB     = 0;

    // internal frequency select codes: 2, 4, 8, 16 MHz
    localparam logic [1:0] SCS_IFREQ_2MHZ  = 2'h0;
    localparam logic [1:0] SCS_IFREQ_4MHZ  = 2'h1;
    localparam logic [1:0] SCS_IFREQ_8MHZ  = 2'h2;
    localparam logic [1:0] SCS_IFREQ_16MHZ = 2'h3;

    // external mode codes
    localparam logic [2:0] SCS_XMODE_OFF0      = 3'h0;
    localparam logic [2:0] SCS_XMODE_OFF1      = 3'h1;
    localparam logic [2:0] SCS_XMODE_CMOS      = 3'h2;
    localparam logic [2:0] SCS_XMODE_CMOS_DIV2 = 3'h3;
    localparam logic [2:0] SCS_XMODE_RC0_DIV2  = 3'h4;
    localparam logic [2:0] SCS_XMODE_RC1_DIV2  = 3'h5;
    localparam logic [2:0] SCS_XMODE_XTAL      = 3'h6;
    localparam logic [2:0] SCS_XMODE_XTAL_DIV2 = 3'h7;

    // timing
    localparam int SCS_REF_CLK_KHZ        = 25000;
    localparam int SCS_MISSING_TIME_US    = 100;
    localparam int SCS_MISSING_CYC        =
        (SCS_MISSING_TIME_US * SCS_REF_CLK_KHZ) / 1000;
    localparam int SCS_XTAL_SETTLE_TIME_US = 1000;
    localparam int SCS_XTAL_SETTLE_CYC    =
        (SCS_XTAL_SETTLE_TIME_US * SCS_REF_CLK_KHZ) / 1000;
    localparam int SCS_MON_W              = 12;
    localparam int SCS_SETTLE_W           = 16;

    typedef struct packed {
        logic       missing_clock_enable;
        logic       sysclk_source_select;
        logic       int_osc_enable;
        logic [1:0] int_freq_select;
    } scs_int_ctrl_t;

    typedef struct packed {
        logic [2:0] ext_osc_mode;
        logic [2:0] ext_drive_select;
    } scs_ext_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } scs_sfr_req_t;

endpackage : scs_pkg
